// *** logic/lds_seq.sv ***
// Load diagnostic sequencer: offline short tests, passive open-load
// test, active open-load counting, fault latching and AHB-Lite slave.
// Assumes analog comparators and current sources sit outside.
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lds_seq #(
  parameter int unsigned RT0_CYC_P = lds_pkg::RT0_CYC,
  parameter int unsigned RT1_CYC_P = lds_pkg::RT1_CYC,
  parameter int unsigned RT2_CYC_P = lds_pkg::RT2_CYC,
  parameter int unsigned RT3_CYC_P = lds_pkg::RT3_CYC,
  parameter int unsigned SHT_CYC_P = lds_pkg::SHT_CYC
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     ce,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  input  wire logic                     strap_variant,
  input  wire logic                     diag_disable_pin,
  input  wire logic                     wake_pulse,
  input  wire logic                     enable_reset_pulse,
  input  wire logic [lds_pkg::NPWM-1:0] pwm_in,
  input  wire logic [lds_pkg::NPH-1:0]  pullup_open_cmp,
  input  wire logic [lds_pkg::NPH-1:0]  pulldown_open_cmp,
  input  wire logic [lds_pkg::NPH-1:0]  drain_short_cmp,
  input  wire logic [lds_pkg::NPH-1:0]  source_short_cmp,
  input  wire logic [lds_pkg::NPH-1:0]  ola_miss,
  input  wire logic [lds_pkg::NPH-1:0]  ola_freewheel,
  output logic                          fault_indicator_n,
  output logic                          fets_off,
  output logic [lds_pkg::NPH-1:0]       pullup_src_en,
  output logic [lds_pkg::NPH-1:0]       pulldown_src_en,
  output logic [lds_pkg::NPH-1:0]       drain_pd_en,
  output logic [lds_pkg::NPH-1:0]       source_pu_en,
  output logic                          charge_pump_en
);
  import lds_pkg::*;

  typedef struct packed {
    lds_state_e      st;
    lds_cnt_t        cnt;
    logic            olp_start;
    logic            sht_start;
    logic [1:0]      sel;
    logic [NPH-1:0]  ola_en;
    logic [NPH-1:0]  ol_ph;
    logic [NPH-1:0]  sb_ph;
    logic [NPH-1:0]  sg_ph;
    logic [NPH-1:0]  pu_seen;
    logic [NPWM-1:0] pwm_q;
    logic            wr_ctrl;
    logic [31:0]     rdata;
    logic            ready;
    logic            resp;
    logic            fault_n;
    logic            fets_off;
    logic            cp_en;
    logic [NPH-1:0]  pu_en;
    logic [NPH-1:0]  pd_en;
    logic [NPH-1:0]  dpd_en;
    logic [NPH-1:0]  spu_en;
  } lds_seq_s;

  lds_seq_s       r;
  lds_seq_s       n;
  logic [NPH-1:0] ola_hit;
  logic [NPH-1:0] ola_on;
  logic           addr_ok;
  logic           clr;
  logic           pwm_chg;
  logic           stop_req;
  logic           olp_run;
  lds_cnt_t       rt;
  lds_cnt_t       half;
  lds_cnt_t       dur;
  logic [31:0]    ctrl_rd;
  logic [31:0]    stat_rd;
  logic [NPH-1:0] sb_new;
  logic [NPH-1:0] sg_new;

  // ----------------------------------------------------------------
  // Run time selection
  // ----------------------------------------------------------------
  function automatic lds_cnt_t rt_cyc(input logic [1:0] s);
    unique case (s)
      2'h0:    rt_cyc = lds_cnt_t'(RT0_CYC_P);
      2'h1:    rt_cyc = lds_cnt_t'(RT1_CYC_P);
      2'h2:    rt_cyc = lds_cnt_t'(RT2_CYC_P);
      default: rt_cyc = lds_cnt_t'(RT3_CYC_P);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Active open-load counters, one per half-bridge
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPH; gi++) begin : g_ola
      // Strap variant follows the pin; register variant is per phase
      assign ola_on[gi] = strap_variant ? !diag_disable_pin : r.ola_en[gi];
      lds_ola_cnt u_cnt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .clr     (clr),
        .ena     (ola_on[gi]),
        .miss    (ola_miss[gi]),
        .fwheel  (ola_freewheel[gi]),
        .report  (ola_hit[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read views of the registers
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_rd = 32'h0;
    ctrl_rd[CTRL_OLP] = r.olp_start;
    ctrl_rd[CTRL_SHT] = r.sht_start;
    ctrl_rd[CTRL_SEL_LO +: 2] = r.sel;
    ctrl_rd[CTRL_OLA_LO +: NPH] = r.ola_en;
    stat_rd = 32'h0;
    stat_rd[ST_FAULT] = |{r.ol_ph, r.sb_ph, r.sg_ph};
    stat_rd[ST_OLD] = |r.ol_ph;
    stat_rd[ST_OLSHT] = |{r.ol_ph, r.sb_ph, r.sg_ph};
    stat_rd[ST_OLPH_LO +: NPH] = r.ol_ph;
    stat_rd[ST_SB_LO +: NPH] = r.sb_ph;
    stat_rd[ST_SG_LO +: NPH] = r.sg_ph;
    stat_rd[ST_BUSY] = r.st != S_IDLE;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    // Zero wait states keep the slave simple; every answer is OKAY
    n.ready = 1'b1;
    n.resp = 1'b0;
    addr_ok = hsel && hready && htrans[1];
    n.wr_ctrl = addr_ok && hwrite && hsize == SIZE_WORD &&
                haddr[ADDR_W-1:0] == ADDR_CTRL;
    if (addr_ok && !hwrite) begin
      if (haddr[ADDR_W-1:0] == ADDR_CTRL) begin
        n.rdata = ctrl_rd;
      end else if (haddr[ADDR_W-1:0] == ADDR_STAT) begin
        n.rdata = stat_rd;
      end else begin
        n.rdata = 32'h0;
      end
    end

    // Clear by register bit or by the enable reset pulse
    clr = (r.wr_ctrl && hwdata[CTRL_CLR]) || enable_reset_pulse;
    pwm_chg = pwm_in != r.pwm_q;
    n.pwm_q = pwm_in;
    olp_run = r.st == S_OLP_PU || r.st == S_OLP_PD;
    stop_req = r.wr_ctrl && !hwdata[CTRL_OLP];
    if (clr) begin
      n.ol_ph = '0;
      n.sb_ph = '0;
      n.sg_ph = '0;
    end
    if (wake_pulse) begin
      n.ol_ph = '0;
    end

    // Control writes; start bits are not retaken while a test runs
    if (r.wr_ctrl) begin
      n.sel = hwdata[CTRL_SEL_LO +: 2];
      n.ola_en = hwdata[CTRL_OLA_LO +: NPH];
      if (r.st == S_IDLE) begin
        n.sht_start = hwdata[CTRL_SHT];
        n.olp_start = hwdata[CTRL_OLP];
      end
    end
    // Strap variant starts the whole chain at wake unless disabled
    // A wake seen mid-test is ignored so a running step keeps its start bit
    if (wake_pulse && strap_variant && !diag_disable_pin && r.st == S_IDLE) begin
      n.sht_start = 1'b1;
      n.olp_start = 1'b1;
    end
    if (wake_pulse && strap_variant && diag_disable_pin && r.st == S_IDLE) begin
      n.olp_start = 1'b0;
    end

    rt = rt_cyc(n.sel);
    half = rt >> 1;
    dur = strap_variant ? lds_cnt_t'(SHT_CYC_P) : rt;
    sb_new = '0;
    sg_new = '0;

    unique case (r.st)
      S_IDLE: begin
        if (n.sht_start) begin
          n.st = S_SHT_SUP;
          n.cnt = dur - 1'b1;
        end else if (n.olp_start) begin
          n.st = S_OLP_PU;
          n.cnt = half - 1'b1;
        end
      end
      S_SHT_SUP: begin
        if (r.cnt == '0) begin
          sb_new = drain_short_cmp;
          n.st = S_SHORT_TO_GROUND_TEST;
          n.cnt = dur - 1'b1;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      S_SHORT_TO_GROUND_TEST: begin
        if (r.cnt == '0) begin
          sg_new = source_short_cmp;
          n.sht_start = 1'b0;
          // Any short seen blocks the passive step so only it shows
          if (n.olp_start && !(|{r.sb_ph, r.sg_ph, source_short_cmp})) begin
            n.st = S_OLP_PU;
            n.cnt = half - 1'b1;
          end else begin
            n.st = S_IDLE;
            n.olp_start = 1'b0;
          end
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      S_OLP_PU: begin
        if (pwm_chg || stop_req) begin
          n.st = S_IDLE;
          n.olp_start = 1'b0;
        end else if (r.cnt == '0) begin
          n.pu_seen = pullup_open_cmp;
          n.st = S_OLP_PD;
          n.cnt = rt - half - 1'b1;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      S_OLP_PD: begin
        if (pwm_chg || stop_req) begin
          n.st = S_IDLE;
          n.olp_start = 1'b0;
        end else if (r.cnt == '0) begin
          n.ol_ph = n.ol_ph | (r.pu_seen & pulldown_open_cmp);
          n.st = S_IDLE;
          n.olp_start = 1'b0;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      default: begin
        n.st = S_IDLE;
        n.olp_start = 1'b0;
        n.sht_start = 1'b0;
      end
    endcase

    // Sets are applied after clears so a coincident event survives
    n.sb_ph = n.sb_ph | sb_new;
    n.sg_ph = n.sg_ph | sg_new;
    n.ol_ph = n.ol_ph | ola_hit;

    // Pin and source controls are registered copies of the next state
    n.fault_n = !(|{n.ol_ph, n.sb_ph, n.sg_ph});
    n.fets_off = n.st != S_IDLE;
    n.cp_en = 1'b1;
    n.pu_en = {NPH{n.st == S_OLP_PU}};
    n.pd_en = {NPH{n.st == S_OLP_PD}};
    n.dpd_en = {NPH{n.st == S_SHT_SUP}};
    n.spu_en = {NPH{n.st == S_SHORT_TO_GROUND_TEST}};
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{st: S_IDLE, ready: 1'b1, fault_n: 1'b1, cp_en: 1'b1, default: '0};
    end else if (ce) begin
      r <= n;
    end
  end

  assign hreadyout         = r.ready;
  assign hresp             = r.resp;
  assign hrdata            = r.rdata;
  assign fault_indicator_n = r.fault_n;
  assign fets_off          = r.fets_off;
  assign pullup_src_en     = r.pu_en;
  assign pulldown_src_en   = r.pd_en;
  assign drain_pd_en       = r.dpd_en;
  assign source_pu_en      = r.spu_en;
  assign charge_pump_en    = r.cp_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_sup_done;
    ce && r.st == S_SHT_SUP && r.cnt == '0;
  endsequence
  sequence s_pd_end;
    ce && r.st == S_OLP_PD && r.cnt == '0 && !pwm_chg && !stop_req;
  endsequence

  a_fets_off_test: assert property (r.st != S_IDLE |-> fets_off)
    else $error("switches not held off during test");
  a_fault_pin_flag: assert property ((|{r.ol_ph, r.sb_ph, r.sg_ph}) |-> !fault_indicator_n)
    else $error("latched flag without fault pin low");
  a_pd_after_pu: assert property ($rose(r.st == S_OLP_PD) |-> $past(r.st) == S_OLP_PU)
    else $error("pull-down step not preceded by pull-up step");
  a_sup_then_gnd: assert property (s_sup_done |=> r.st == S_SHORT_TO_GROUND_TEST && r.cnt == dur - 1'b1)
    else $error("ground short step did not follow supply step");
  a_abort_no_fault: assert property (ce && olp_run && pwm_chg && !clr && !(|ola_hit)
    && !wake_pulse |=> r.st == S_IDLE && !r.olp_start && r.ol_ph == $past(r.ol_ph))
    else $error("passive abort misbehaved");
  a_olp_no_short: assert property ($rose(r.st == S_OLP_PU) && $past(r.st) == S_SHORT_TO_GROUND_TEST
    |-> r.sg_ph == '0 && r.sb_ph == '0)
    else $error("passive test ran after a short");
  a_start_held: assert property (olp_run |-> r.olp_start)
    else $error("start bit dropped during passive test");
  a_start_return: assert property (s_pd_end |=> !r.olp_start && r.st == S_IDLE)
    else $error("start bit not returned after run time");
  a_pump_on_fault: assert property ((|r.ol_ph) |-> charge_pump_en)
    else $error("charge pump off with open load latched");
  a_clear_flags: assert property (ce && enable_reset_pulse && r.st == S_IDLE && !(|ola_hit)
    |=> r.ol_ph == '0 ##1 fault_indicator_n || !ce || (|r.ol_ph) || (|r.sb_ph) || (|r.sg_ph))
    else $error("clear did not release flags");

endmodule // lds_seq
`default_nettype wire

// *** logic/lds_pkg.sv ***
// Constants shared by the load diagnostic sequencer and its counter.
// Assumes a single 40 MHz core clock and an AHB-Lite register port.
package lds_pkg;

  // ----------------------------------------------------------------
  // Clock and run times
  // ----------------------------------------------------------------
  localparam int CLK_MHZ    = 40;
  localparam int RT0_US     = 250;    // Passive run time 0.25 ms
  localparam int RT1_US     = 1250;   // Passive run time 1.25 ms
  localparam int RT2_US     = 5000;   // Passive run time 5 ms
  localparam int RT3_US     = 11500;  // Passive run time 11.5 ms
  localparam int SHT_FIX_US = 2000;   // Strap variant short test 2 ms
  localparam int RT0_CYC    = RT0_US * CLK_MHZ;
  localparam int RT1_CYC    = RT1_US * CLK_MHZ;
  localparam int RT2_CYC    = RT2_US * CLK_MHZ;
  localparam int RT3_CYC    = RT3_US * CLK_MHZ;
  localparam int SHT_CYC    = SHT_FIX_US * CLK_MHZ;
  localparam int CNT_W      = 20;
  typedef logic [CNT_W-1:0] lds_cnt_t;

  // Analog comparator floor for the active check, informative only
  localparam int OLA_THR_MIN_MV = 150;

  // ----------------------------------------------------------------
  // Phases, inputs, active check limit
  // ----------------------------------------------------------------
  localparam int NPH     = 3;
  localparam int NPWM    = 6;
  localparam logic [1:0] OLA_LIMIT = 2'h3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam int CTRL_OLP    = 0;     // passive_ol_start
  localparam int CTRL_SHT    = 1;     // short_test_start
  localparam int CTRL_CLR    = 2;     // clear_faults_bit, self clearing
  localparam int CTRL_SEL_LO = 3;     // diag_run_time_sel, 2 bits
  localparam int CTRL_OLA_LO = 5;     // active_ol_enable, 3 bits
  localparam int ST_FAULT    = 0;
  localparam int ST_OLD      = 1;     // open_load_flag
  localparam int ST_OLSHT    = 2;     // load_or_short_flag
  localparam int ST_OLPH_LO  = 3;     // phase_open_load_flag
  localparam int ST_SB_LO    = 6;     // phase_short_supply_flag
  localparam int ST_SG_LO    = 9;     // phase short-to-ground flag
  localparam int ST_BUSY     = 12;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE    = 5'h01,
    S_SHT_SUP = 5'h02,
    S_SHORT_TO_GROUND_TEST = 5'h04,
    S_OLP_PU  = 5'h08,
    S_OLP_PD  = 5'h10
  } lds_state_e;

endpackage

// *** logic/lds_ola_cnt.sv ***
// Per-phase failure counter for the active open-load check.
// Assumes miss and freewheel strobes arrive once per PWM cycle.
`timescale 1ns/1ps
`default_nettype none
module lds_ola_cnt (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic clr,
  input  wire logic ena,
  input  wire logic miss,
  input  wire logic fwheel,
  output logic      report
);
  import lds_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic       report;
  } lds_olc_s;

  lds_olc_s r;
  lds_olc_s n;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Freewheeling restarts the count so isolated misses never report
  always_comb begin
    n = r;
    n.report = 1'b0;
    if (clr || !ena || fwheel) begin
      n.cnt = 2'h0;
    end else if (miss) begin
      if (r.cnt == OLA_LIMIT - 2'h1) begin
        n.report = 1'b1;
        n.cnt    = 2'h0;
      end else begin
        n.cnt = r.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign report = r.report;

  a_ola_third_miss: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && ena && !clr && !fwheel && miss && r.cnt == 2'h2) |=> report)
    else $error("third consecutive miss did not report");

endmodule // lds_ola_cnt
`default_nettype wire

// *** sim/lds_load_model.sv ***
// Behavioural model of the bridges, motor load and sense comparators.
// Assumes the bench changes the fault masks only right after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module lds_load_model (
  input  wire logic [lds_pkg::NPH-1:0] pu_en,
  input  wire logic [lds_pkg::NPH-1:0] pd_en,
  input  wire logic [lds_pkg::NPH-1:0] drain_en,
  input  wire logic [lds_pkg::NPH-1:0] source_en,
  input  wire logic [lds_pkg::NPH-1:0] open_m,
  input  wire logic [lds_pkg::NPH-1:0] sup_m,
  input  wire logic [lds_pkg::NPH-1:0] gnd_m,
  output logic      [lds_pkg::NPH-1:0] pu_cmp,
  output logic      [lds_pkg::NPH-1:0] pd_cmp,
  output logic      [lds_pkg::NPH-1:0] drain_cmp,
  output logic      [lds_pkg::NPH-1:0] source_cmp
);
  import lds_pkg::*;
  // A comparator only trips while its source is on, so a wrong step shows
  assign pu_cmp     = pu_en & open_m;
  assign pd_cmp     = pd_en & open_m;
  assign drain_cmp  = drain_en & sup_m;
  assign source_cmp = source_en & gnd_m;
endmodule // lds_load_model
`default_nettype wire

// *** sim/load_diagnostic_sequencer_test.sv ***
// Self-checking bench for the load diagnostic sequencer.
// Assumes the small run-time parameters below and a zero-wait AHB slave.
`timescale 1ns/1ps
`default_nettype none
module load_diagnostic_sequencer_test;
  import lds_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = SIZE_WORD;
  logic strap = 0, dpin = 0, wake = 0, erst = 0, dph = 0, ce = 1, fn, foff, cp;
  logic [5:0] pwm = 0;
  logic [2:0] om = 0, sm = 0, gm = 0, ms = 0, fw = 0, pc, dc, ssc, gsc, pue, pde, dre, sre;
  logic [63:0] q[$];
  int failures = 0, compares = 0, p, k;
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  lds_seq #(.RT0_CYC_P(8), .RT1_CYC_P(10), .RT2_CYC_P(12), .RT3_CYC_P(16),
    .SHT_CYC_P(10)) dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .strap_variant(strap), .diag_disable_pin(dpin), .wake_pulse(wake),
    .enable_reset_pulse(erst), .pwm_in(pwm), .pullup_open_cmp(pc),
    .pulldown_open_cmp(dc), .drain_short_cmp(ssc), .source_short_cmp(gsc),
    .ola_miss(ms), .ola_freewheel(fw), .fault_indicator_n(fn), .fets_off(foff),
    .pullup_src_en(pue), .pulldown_src_en(pde), .drain_pd_en(dre),
    .source_pu_en(sre), .charge_pump_en(cp));
  lds_load_model load (.pu_en(pue), .pd_en(pde), .drain_en(dre), .source_en(sre),
    .open_m(om), .sup_m(sm), .gnd_m(gm), .pu_cmp(pc), .pd_cmp(dc),
    .drain_cmp(ssc), .source_cmp(gsc));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Read data phase: oldest note holds mask in the upper word
  always @(posedge hclk) begin
    logic [63:0] n;
    if (dph && hreadyout === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      check(hrdata & n[63:32], n[31:0] & n[63:32]);
    end
  end
  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    int i;
    @(posedge hclk);
    hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) begin failures++; print_verdict(); end
    if (!w) q.push_back({m, d});
    hsel <= 0; htrans <= 2'h0; hwdata <= w ? d : 32'h0; dph <= !w;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) begin failures++; print_verdict(); end
    dph <= 0;
  endtask
  task automatic wait_off();
    int i;
    // Let the edge that starts a test settle before looking at the pin
    @(posedge hclk);
    for (i = 0; i < 400 && foff !== 1'b0; i++) @(posedge hclk);
    if (i == 400) begin failures++; print_verdict(); end
    repeat (3) @(posedge hclk);
  endtask
  task automatic clr();
    ahb(1, ADDR_CTRL, 32'h4, 0);
    ahb(0, ADDR_STAT, 32'h0, 32'hFFFF_FFFF);
  endtask
  task automatic ola(input logic m);
    @(posedge hclk); ms <= m ? 3'h1 : 3'h0; fw <= m ? 3'h0 : 3'h1;
    @(posedge hclk); ms <= 0; fw <= 0;
    repeat (2) @(posedge hclk);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h3bd1));
    p = $urandom % 3;
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk); check(fn, 1); check(cp, 1); check(hresp, 0);
    ahb(0, ADDR_STAT, 32'h0, 32'hFFFF_FFFF); ahb(0, 8'h40, 32'h0, 32'hFFFF_FFFF);
    $display("test reset done");
    // Passive open load on a random phase, longest run time
    om <= 3'h1 << p;
    ahb(1, ADDR_CTRL, 32'h19, 0);
    @(negedge hclk); check(foff, 1);
    ahb(0, ADDR_CTRL, 32'h1, 32'h1);
    wait_off();
    check(fn, 0); check(cp, 1);
    ahb(0, ADDR_STAT, 32'h7 | (32'h8 << p), 32'hFFF);
    wake <= 1; @(posedge hclk); wake <= 0;
    ahb(0, ADDR_STAT, 32'h0, 32'h38);
    clr(); check(fn, 1);
    $display("test passive done");
    // Pull-up trips alone: no flag; then pwm change aborts
    om <= 3'h1 << p; ahb(1, ADDR_CTRL, 32'h1, 0);
    for (k = 0; k < 50 && pde === 3'h0; k++) @(posedge hclk);
    if (k == 50) begin failures++; print_verdict(); end
    om <= 0; wait_off(); ahb(0, ADDR_STAT, 32'h0, 32'hFFF);
    // Clock enable low freezes the run: switches stay off past the run time
    ahb(1, ADDR_CTRL, 32'h1, 0); ce <= 0; repeat (20) @(posedge hclk);
    check(foff, 1); ce <= 1; wait_off();
    ahb(0, ADDR_STAT, 32'h0, 32'hFFF);
    om <= 3'h7; ahb(1, ADDR_CTRL, 32'h11, 0);
    pwm <= 6'h01; wait_off(); pwm <= 0;
    ahb(0, ADDR_STAT, 32'h0, 32'hFFF); check(fn, 1);
    ahb(1, ADDR_CTRL, 32'h11, 0); ahb(1, ADDR_CTRL, 32'h10, 0);
    wait_off(); ahb(0, ADDR_STAT, 32'h0, 32'hFFF);
    $display("test abort done");
    // Shorts block the passive step
    om <= 3'h1 << p; sm <= 3'h4;
    ahb(1, ADDR_CTRL, 32'h3, 0); wait_off();
    ahb(0, ADDR_STAT, 32'h105, 32'hFFF); check(fn, 0);
    ahb(0, ADDR_CTRL, 32'h0, 32'h1); clr();
    sm <= 0; gm <= 3'h1;
    ahb(1, ADDR_CTRL, 32'h3, 0); wait_off();
    ahb(0, ADDR_STAT, 32'h205, 32'hFFF);
    erst <= 1; @(posedge hclk); erst <= 0; gm <= 0;
    ahb(0, ADDR_STAT, 32'h0, 32'hFFF);
    $display("test shorts done");
    // Active counter: freewheel restarts, third miss reports
    ahb(1, ADDR_CTRL, 32'hE0, 0);
    ola(1); ola(1); ola(0); ola(1); ola(1);
    ahb(0, ADDR_STAT, 32'h0, 32'hFFF); check(fn, 1);
    ola(1); ola(0);
    ahb(0, ADDR_STAT, 32'hF, 32'hFFF); check(fn, 0);
    clr();
    $display("test active done");
    // Strap variant: wake runs shorts then passive; pin high skips
    strap <= 1; dpin <= 0; om <= 3'h1 << p;
    wake <= 1; @(posedge hclk); wake <= 0; @(posedge hclk);
    check(foff, 1); wait_off();
    ahb(0, ADDR_STAT, 32'h7 | (32'h8 << p), 32'hFFF);
    clr(); dpin <= 1;
    wake <= 1; @(posedge hclk); wake <= 0; repeat (3) @(posedge hclk);
    check(foff, 0); ahb(0, ADDR_STAT, 32'h0, 32'hFFF);
    $display("test strap done");
    print_verdict();
  end
endmodule // load_diagnostic_sequencer_test
`default_nettype wire
